// File: common/aws_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the auto-wake/sleep block.
// Assumes: Byte-wide registers at their printed offsets; 25 MHz system clock.
// Notes:   Definitions only.
`ifndef AWS_DEFS_SVH
`define AWS_DEFS_SVH
`define AWS_ADDR_CTRL_ONE      8'h2A
`define AWS_ADDR_CTRL_TWO      8'h2B
`define AWS_ADDR_WAKE_SRC      8'h2C
`define AWS_ADDR_INT_EN        8'h2D
`define AWS_ADDR_INACT_DUR     8'h29
`define AWS_ADDR_SYS_MODE      8'h0B
`define AWS_RST_BYTE           8'h00
`define AWS_BIT_ACTIVE         0
`define AWS_BIT_AUTOSLEEP_ENABLE           2
`define AWS_BIT_GATE           7
`define AWS_BIT_INT_SLEEP      7
`define AWS_STEP_SHORT_MS      320
`define AWS_STEP_LONG_MS       640
`define AWS_CLK_HZ             25000000
`define AWS_WAKE_SLOWEST       3'h7
`endif

// File: common/aws_pkg.sv
// Purpose: Types shared by the auto-wake/sleep block.
// Assumes: Nothing beyond the header of constants.
// Notes:   Event bundle order follows the wake-source bits 3 to 6.
package aws_pkg;
  typedef enum logic [1:0] {
    AWS_STANDBY = 2'b00,
    AWS_WAKE    = 2'b01,
    AWS_SLEEP   = 2'b11
  } aws_mode_t;

  typedef struct packed {
    logic transient;
    logic orientation;
    logic tap;
    logic motion_freefall;
  } aws_evt_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aws_reg_req_t;
endpackage

// File: hdl/aws_tick_div.sv
// Purpose: Divider giving one-cycle tick pulses at a programmable period.
// Assumes: Period in clock cycles is at least one.
// Notes:   A restart realigns the phase so a new period starts cleanly.
module aws_tick_div #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         rst_n,    // Synchronous reset, active low.
  input  wire logic         restart,  // Restart the period.
  input  wire logic [W-1:0] period,   // Period in cycles.
  output logic              tick      // One-cycle pulse per period.
);
  logic [W-1:0] cnt;
  initial begin
    if (W < 2) $error("aws_tick_div: width too small");
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || restart) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt >= period - W'(1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + W'(1);
      tick <= 1'b0;
    end
  end
endmodule // aws_tick_div

// File: hdl/aws_ctrl.sv
// Purpose: Auto-wake/sleep control of a motion sensor's sample rate.
// Assumes: Byte register port; detection events are one-cycle pulses on clk_sys.
// Notes:   The step of the inactivity timer is a parameter so simulation can shorten it.
`include "aws_defs.svh"
module aws_ctrl
  import aws_pkg::*;
#(
  parameter int STEP_SHORT_CYC = (`AWS_STEP_SHORT_MS * (`AWS_CLK_HZ / 1000)),
  parameter int STEP_LONG_CYC  = (`AWS_STEP_LONG_MS * (`AWS_CLK_HZ / 1000))
) (
  input  wire logic          clk_sys,          // System clock, 25 MHz.
  input  wire logic          rst_n,            // Synchronous reset, active low.
  input  aws_pkg::aws_reg_req_t reg_req,       // Register request, valid one cycle.
  input  wire logic          reg_rd,           // Register read strobe.
  output logic [7:0]         reg_rdata,        // Read data, one cycle after strobe.
  input  aws_pkg::aws_evt_t  det_evt,          // Detection event pulses.
  input  wire logic          gate_evt,         // Buffer-gate event pulse.
  input  wire logic          sleep_evt_in,     // Sleep-transition interrupt pulse.
  input  wire logic          ready_evt_in,     // Sample-ready interrupt pulse.
  input  wire logic          buf_flush,        // Host flush of sample buffer.
  output aws_pkg::aws_mode_t sys_mode,         // Current system mode.
  output logic [2:0]         rate_code,        // Effective rate code for all blocks.
  output logic               buf_accept,       // Sample buffer may store samples.
  output logic               sleep_irq         // Transition interrupt pulse.
);
  import aws_pkg::*;

  initial begin
    if (STEP_SHORT_CYC < 2 || STEP_LONG_CYC < 2) $error("aws_ctrl: step too short");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] inactivity_duration;
  logic [7:0] ctrl_one;
  logic [7:0] system_control_two;
  logic [7:0] wake_source_control;
  logic [7:0] interrupt_enable_control;
  logic [1:0] sleep_rate_select;
  logic [2:0] wake_rate_select;
  logic       active;
  logic       autosleep_enable;
  logic       gate_enable;

  assign sleep_rate_select = ctrl_one[7:6];
  assign wake_rate_select  = ctrl_one[5:3];
  assign active            = ctrl_one[`AWS_BIT_ACTIVE];
  assign autosleep_enable  = system_control_two[`AWS_BIT_AUTOSLEEP_ENABLE];
  assign gate_enable       = wake_source_control[`AWS_BIT_GATE];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inactivity_duration      <= `AWS_RST_BYTE;
      ctrl_one                 <= `AWS_RST_BYTE;
      system_control_two       <= `AWS_RST_BYTE;
      wake_source_control      <= `AWS_RST_BYTE;
      interrupt_enable_control <= `AWS_RST_BYTE;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `AWS_ADDR_INACT_DUR: inactivity_duration      <= reg_req.wdata;
        `AWS_ADDR_CTRL_ONE:  ctrl_one                 <= reg_req.wdata;
        `AWS_ADDR_CTRL_TWO:  system_control_two       <= reg_req.wdata & 8'h1F;
        `AWS_ADDR_WAKE_SRC:  wake_source_control      <= reg_req.wdata;
        `AWS_ADDR_INT_EN:    interrupt_enable_control <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  logic [7:0] rd_mux;
  assign rd_mux = (reg_req.addr == `AWS_ADDR_INACT_DUR) ? inactivity_duration :
                  (reg_req.addr == `AWS_ADDR_CTRL_ONE)  ? ctrl_one :
                  (reg_req.addr == `AWS_ADDR_CTRL_TWO)  ? system_control_two :
                  (reg_req.addr == `AWS_ADDR_WAKE_SRC)  ? wake_source_control :
                  (reg_req.addr == `AWS_ADDR_INT_EN)    ? interrupt_enable_control :
                  (reg_req.addr == `AWS_ADDR_SYS_MODE)  ? {6'h00, sys_mode} : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification.
  // Wake-source bits 3..6 and interrupt enable bits 3..6 line up with det_evt.
  logic [3:0] evt_vec;
  logic [3:0] wake_sel;
  logic [3:0] int_en;
  logic       restart_evt;
  logic       wake_evt;
  assign evt_vec     = {det_evt.transient, det_evt.orientation, det_evt.tap,
                        det_evt.motion_freefall};
  assign wake_sel    = wake_source_control[6:3];
  assign int_en      = interrupt_enable_control[6:3];
  // The sleep and sample-ready inputs are deliberately left out of both terms.
  assign restart_evt = (|evt_vec) || gate_evt;
  assign wake_evt    = |(evt_vec & wake_sel & int_en);

  ////////////////////////////////////////////////////////////////////////////
  // Inactivity timer.
  logic        slow_wake;
  logic [31:0] step_period;
  logic        step_tick;
  logic [7:0]  elapsed;
  logic        expire;
  logic        wake_entry;
  aws_mode_t   next_mode;
  assign slow_wake   = (wake_rate_select == `AWS_WAKE_SLOWEST);
  assign step_period = slow_wake ? 32'(STEP_LONG_CYC) : 32'(STEP_SHORT_CYC);
  assign wake_entry  = (sys_mode != AWS_WAKE) && (next_mode == AWS_WAKE);

  aws_tick_div #(.W(32)) u_step (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .restart (restart_evt || wake_entry || sys_mode != AWS_WAKE),
    .period  (step_period),
    .tick    (step_tick)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n || restart_evt || wake_entry || sys_mode != AWS_WAKE) begin
      elapsed <= 8'h00;
    end else if (step_tick && elapsed != 8'hFF) begin
      elapsed <= elapsed + 8'h01;
    end
  end
  assign expire = autosleep_enable && (elapsed >= inactivity_duration);

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing.
  always_comb begin
    next_mode = sys_mode;
    case (sys_mode)
      AWS_STANDBY: if (active) next_mode = AWS_WAKE;
      AWS_WAKE: begin
        if (!active) next_mode = AWS_STANDBY;
        else if (expire && !restart_evt) next_mode = AWS_SLEEP;
      end
      AWS_SLEEP: begin
        if (!active) next_mode = AWS_STANDBY;
        else if (wake_evt || !autosleep_enable) next_mode = AWS_WAKE;
      end
      default: next_mode = AWS_STANDBY;
    endcase
  end

  logic transition;
  assign transition = ((sys_mode == AWS_WAKE) && (next_mode == AWS_SLEEP)) ||
                      ((sys_mode == AWS_SLEEP) && (next_mode == AWS_WAKE));

  // Sleep rates map onto the wake-rate codes 50, 12.5, 6.25 and 1.56 Hz.
  logic [2:0] sleep_code;
  logic [2:0] next_rate;
  assign sleep_code = (sleep_rate_select == 2'b00) ? 3'h4 :
                      (sleep_rate_select == 2'b01) ? 3'h5 :
                      (sleep_rate_select == 2'b10) ? 3'h6 : 3'h7;
  assign next_rate  = (next_mode == AWS_SLEEP) ? sleep_code : wake_rate_select;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_mode  <= AWS_STANDBY;
      rate_code <= 3'h0;
      sleep_irq <= 1'b0;
    end else begin
      sys_mode  <= next_mode;
      rate_code <= next_rate;
      sleep_irq <= transition && interrupt_enable_control[`AWS_BIT_INT_SLEEP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer gate.
  // The transition is never held back; only the buffer stops accepting.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) buf_accept <= 1'b1;
    else if (transition && gate_enable) buf_accept <= 1'b0;
    else if (buf_flush) buf_accept <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_no_sleep_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !autosleep_enable |=> sys_mode != AWS_SLEEP;
  endproperty
  a_no_sleep_off: assert property (p_no_sleep_off) else $error("sleep entered");

  property p_wake_on_evt;
    @(posedge clk_sys) disable iff (!rst_n)
      (sys_mode == AWS_SLEEP && active && wake_evt) |=> sys_mode == AWS_WAKE;
  endproperty
  a_wake_on_evt: assert property (p_wake_on_evt) else $error("no wake on event");

  property p_gate_no_wake;
    @(posedge clk_sys) disable iff (!rst_n)
      (sys_mode == AWS_SLEEP && active && autosleep_enable && !wake_evt)
        |=> sys_mode != AWS_WAKE;
  endproperty
  a_gate_no_wake: assert property (p_gate_no_wake) else $error("bad wake");

  property p_restart_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      restart_evt |=> elapsed == 8'h00;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("timer kept");

  property p_sleep_rate;
    @(posedge clk_sys) disable iff (!rst_n)
      sys_mode == AWS_SLEEP |-> rate_code == sleep_code;
  endproperty
  a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate wrong");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      (transition && interrupt_enable_control[`AWS_BIT_INT_SLEEP]) |=> sleep_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing interrupt");

  property p_gate_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (transition && gate_enable) |=> !buf_accept;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("buffer not gated");

  property p_flush;
    @(posedge clk_sys) disable iff (!rst_n)
      (buf_flush && !(transition && gate_enable)) |=> buf_accept;
  endproperty
  a_flush: assert property (p_flush) else $error("flush ignored");

  property p_expire_sleep;
    @(posedge clk_sys) disable iff (!rst_n)
      (sys_mode == AWS_WAKE && active && expire && !restart_evt) |=> sys_mode == AWS_SLEEP;
  endproperty
  a_expire_sleep: assert property (p_expire_sleep) else $error("no sleep");

  c_sleep: cover property (@(posedge clk_sys) sys_mode == AWS_SLEEP);
  c_wake_back: cover property (@(posedge clk_sys) sys_mode == AWS_SLEEP ##1 sys_mode == AWS_WAKE);
  c_gated: cover property (@(posedge clk_sys) !buf_accept ##1 buf_accept);
endmodule // aws_ctrl

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the auto-wake/sleep control block.
// Assumes: Shortened timer steps of 8 and 16 cycles; single-byte register port.
// Notes:   Assertions live in the design files, so the bench only drives and compares.
`include "aws_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aws_pkg::*;
  localparam int SS = 8;
  localparam int SL = 16;
  logic          clk_sys;
  logic          rst_n;
  aws_reg_req_t  reg_req;
  logic          reg_rd;
  logic [7:0]    reg_rdata;
  aws_evt_t      det_evt;
  logic          gate_evt;
  logic          sleep_evt_in;
  logic          ready_evt_in;
  logic          buf_flush;
  aws_mode_t     sys_mode;
  logic [2:0]    rate_code;
  logic          buf_accept;
  logic          sleep_irq;
  logic [7:0]    irq_cnt;
  logic [7:0]    rdv;
  int            errors;
  int            checks;
  int            cyc = 0;
  aws_ctrl #(.STEP_SHORT_CYC(SS), .STEP_LONG_CYC(SL)) aws_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .det_evt(det_evt), .gate_evt(gate_evt),
    .sleep_evt_in(sleep_evt_in), .ready_evt_in(ready_evt_in), .buf_flush(buf_flush),
    .sys_mode(sys_mode), .rate_code(rate_code), .buf_accept(buf_accept),
    .sleep_irq(sleep_irq)
  );
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse(input logic [3:0] e, input logic [3:0] o);
    @(posedge clk_sys);
    det_evt <= e;
    {gate_evt, sleep_evt_in, ready_evt_in, buf_flush} <= o;
    @(posedge clk_sys);
    det_evt <= '0;
    {gate_evt, sleep_evt_in, ready_evt_in, buf_flush} <= 4'h0;
    #1;
  endtask
  task automatic wait_mode(input aws_mode_t m, input int lo, input int hi);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n <= hi) begin
      @(posedge clk_sys);
      #1 n++;
      hit = (sys_mode === m);
    end
    check({7'h00, hit && n >= lo && n <= hi}, 8'h01);
  endtask
  function automatic logic [7:0] md();
    return {6'h00, sys_mode};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rst_n)
      irq_cnt <= 8'h00;
    else if (sleep_irq === 1'b1)
      irq_cnt <= irq_cnt + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    errors = 0; checks = 0; rst_n = 1'b0; reg_req = '0; reg_rd = 1'b0;
    det_evt = '0; gate_evt = 1'b0; sleep_evt_in = 1'b0; ready_evt_in = 1'b0;
    buf_flush = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check(md(), {6'h00, AWS_STANDBY});
    check({7'h00, buf_accept}, 8'h01);
    rd(`AWS_ADDR_INACT_DUR, rdv); check(rdv, 8'h00);
    rd(8'h3F, rdv); check(rdv, 8'h00);
    wr(`AWS_ADDR_INACT_DUR, 8'hA5);
    rd(`AWS_ADDR_INACT_DUR, rdv); check(rdv, 8'hA5);
    // Auto-sleep off: an expired duration must not put the part to sleep.
    wr(`AWS_ADDR_INACT_DUR, 8'h01);
    wr(`AWS_ADDR_CTRL_ONE, 8'h01);
    repeat (40) @(posedge clk_sys);
    #1 check(md(), {6'h00, AWS_WAKE});
    wr(`AWS_ADDR_CTRL_ONE, 8'h00);
    wr(`AWS_ADDR_INT_EN, 8'hF8);
    wr(`AWS_ADDR_WAKE_SRC, 8'h78);
    wr(`AWS_ADDR_CTRL_TWO, 8'h04);
    wr(`AWS_ADDR_INACT_DUR, 8'h02);
    // Every sleep rate, each woken by a different detection event.
    for (int i = 0; i < 4; i++) begin
      rdv = irq_cnt;
      wr(`AWS_ADDR_CTRL_ONE, {i[1:0], 6'h01});
      wait_mode(AWS_SLEEP, 2 * SS - 2, 2 * SS + 4);
      check({5'h00, rate_code}, 8'h04 + 8'(i));
      // The counter takes the interrupt pulse one edge after it appears.
      @(posedge clk_sys);
      #1 check(irq_cnt, rdv + 8'h01);
      check({7'h00, buf_accept}, 8'h01);
      pulse(4'h1 << i, 4'h0);
      check(md(), {6'h00, AWS_WAKE});
      check({5'h00, rate_code}, 8'h00);
      @(posedge clk_sys);
      #1 check(irq_cnt, rdv + 8'h02);
      wr(`AWS_ADDR_CTRL_ONE, 8'h00);
    end
    // Only one source selected; the others, gate, sleep and ready must not wake.
    wr(`AWS_ADDR_WAKE_SRC, 8'h08);
    wr(`AWS_ADDR_CTRL_ONE, 8'h01);
    wait_mode(AWS_SLEEP, 2 * SS - 2, 2 * SS + 4);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> (i % 3), 4'h0);
      pulse(4'h0, 4'h8 >> i);
      check(md(), {6'h00, AWS_SLEEP});
    end
    // Selected as a wake source but not enabled as an interrupt: no wake.
    wr(`AWS_ADDR_INT_EN, 8'h80);
    pulse(4'h1, 4'h0);
    check(md(), {6'h00, AWS_SLEEP});
    rd(`AWS_ADDR_SYS_MODE, rdv); check(rdv, 8'h03);
    wr(`AWS_ADDR_INT_EN, 8'hF8);
    pulse(4'h1, 4'h0);
    check(md(), {6'h00, AWS_WAKE});
    // Restarting events well inside each period keep the part awake.
    for (int i = 0; i < 6; i++) begin
      repeat (8) @(posedge clk_sys);
      pulse(4'h8, 4'h0);
      repeat (8) @(posedge clk_sys);
      pulse(4'h0, 4'h8);
    end
    check(md(), {6'h00, AWS_WAKE});
    // Sleep and sample-ready pulses must not push the sleep out by more than a cycle.
    pulse(4'h0, 4'h6);
    wait_mode(AWS_SLEEP, 2 * SS - 1, 2 * SS + 1);
    // Slowest wake rate doubles the step.
    wr(`AWS_ADDR_INACT_DUR, 8'h01);
    wr(`AWS_ADDR_CTRL_ONE, 8'h00);
    wr(`AWS_ADDR_CTRL_ONE, 8'h39);
    wait_mode(AWS_SLEEP, SL - 2, SL + 4);
    pulse(4'h1, 4'h0);
    check({5'h00, rate_code}, 8'h07);
    // Gated buffer holds across each transition until flushed.
    wr(`AWS_ADDR_INACT_DUR, 8'h02);
    wr(`AWS_ADDR_WAKE_SRC, 8'h88);
    wr(`AWS_ADDR_CTRL_ONE, 8'h00);
    wr(`AWS_ADDR_CTRL_ONE, 8'h01);
    wait_mode(AWS_SLEEP, 2 * SS - 2, 2 * SS + 4);
    check({7'h00, buf_accept}, 8'h00);
    pulse(4'h0, 4'h1);
    check({7'h00, buf_accept}, 8'h01);
    pulse(4'h1, 4'h0);
    check(md(), {6'h00, AWS_WAKE});
    check({7'h00, buf_accept}, 8'h00);
    pulse(4'h0, 4'h1);
    check({7'h00, buf_accept}, 8'h01);
    // A reset in mid-run brings back standby and the cleared duration.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check(md(), {6'h00, AWS_STANDBY});
    check({5'h00, rate_code}, 8'h00);
    rd(`AWS_ADDR_INACT_DUR, rdv); check(rdv, 8'h00);
    print_verdict();
  end
endmodule // tb_top
